/* File: pkg/mie_cfg.svh */
/*
  Constants of the instruction execute block: opcode fields, selector limits,
  reset values of the held state and the extra hold cycles of branches and the trap.
  Assumes a 14-bit instruction word and an 8-bit data path.
*/
`ifndef MIE_CFG_SVH
`define MIE_CFG_SVH

// six-bit major opcode field, instruction bits 13:8
`define MIE_OP_MISC 6'h00
`define MIE_OP_COPY_REG 6'h01
`define MIE_OP_PLUS_ONE 6'h05
`define MIE_OP_MINUS_ONE 6'h06
`define MIE_OP_OR_REG 6'h09
`define MIE_OP_ROT_RIGHT 6'h0B
`define MIE_OP_ROT_LEFT 6'h0C
`define MIE_OP_PLUS_ONE_SZ 6'h0E
`define MIE_OP_MINUS_ONE_SZ 6'h0F
`define MIE_OP_EXIT_LIT 6'h10
`define MIE_OP_LOAD_LIT 6'h11
`define MIE_OP_OR_LIT 6'h13
`define MIE_OP_SUB_LIT 6'h18
`define MIE_OP_SUB_REG 6'h1D
// short jump uses bits 13:9, long forms bits 13:11
`define MIE_OP_SHORT_JUMP 5'h0D
`define MIE_OP_LONG_CALL 3'h6
`define MIE_OP_LONG_JUMP 3'h7
// full-word computed jump
`define MIE_OP_COMPUTED_JUMP 14'h0213
// misc group low byte codes (bit 7 clear)
`define MIE_MISC_NOP 8'h00
`define MIE_MISC_SLEEP 8'h01
`define MIE_MISC_IRQ_ON 8'h02
`define MIE_MISC_IRQ_OFF 8'h03
`define MIE_MISC_SUB_EXIT 8'h04
`define MIE_MISC_IRQ_EXIT 8'h05
`define MIE_MISC_DEC_ADJ 8'h06
`define MIE_MISC_TRAP 8'h07
// misc group sub-field bits 7:4 for selector forms
`define MIE_SEL_PORT_WR 4'h1
`define MIE_SEL_PORT_RD 4'h2
`define MIE_SEL_SFR_WR 4'h3
`define MIE_SEL_SFR_RD 4'h4
// field positions
`define MIE_DEST_BIT 7
`define MIE_PAGE_BIT 9
// limits and targets
`define MIE_PORT_SEL_MIN 4'h5
`define MIE_TRAP_VECTOR 11'h001
`define MIE_NIBBLE_MAX 4'h9
`define MIE_NIBBLE_ADJ 4'h6
// reset values
`define MIE_RST_ACC 8'h00
`define MIE_RST_GIE 1'b0
`define MIE_RST_TIMEOUT 1'b1
`define MIE_RST_POWER_DOWN 1'b1
// extra hold cycles after the execute cycle
`define MIE_HOLD_BRANCH 2'h1
`define MIE_HOLD_TRAP 2'h2

`endif

/* File: pkg/mie_pkg.sv */
/*
  Types of the instruction execute block: arithmetic operation selector and
  the sequencing states. Assumes nothing beyond the constants header.
*/
package mie_pkg;
  typedef enum logic [2:0] {
    MIE_ALU_PASS,
    MIE_ALU_INC,
    MIE_ALU_DEC,
    MIE_ALU_OR,
    MIE_ALU_ROL,
    MIE_ALU_ROR,
    MIE_ALU_SBC,
    MIE_ALU_DAA
  } mie_alu_op_t;

  typedef enum logic [1:0] {
    MIE_ST_EXEC,
    MIE_ST_HOLD,
    MIE_ST_SLEEP
  } mie_state_t;
endpackage

/* File: pkg/mie_alu_if.sv */
/*
  Carrier between the execute sequencer and its arithmetic unit.
  Assumes both ends sit on the same clock; the unit is purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none
interface mie_alu_if;
  import mie_pkg::*;
  mie_alu_op_t op;
  logic [7:0] a; // working register
  logic [7:0] b; // register operand or immediate
  logic cin; // carry in
  logic dcin; // half carry in
  logic [7:0] res;
  logic cout;
  logic dcout;
  modport seq (output op, a, b, cin, dcin, input res, cout, dcout);
  modport alu (input op, a, b, cin, dcin, output res, cout, dcout);
endinterface
`default_nettype wire

/* File: verilog/mie_alu.sv */
/*
  Arithmetic unit of the execute block: increment, decrement, OR, rotates
  through carry, subtract with borrow and decimal adjust.
  Assumes operands are stable in the cycle the sequencer samples the result.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mie_cfg.svh"
module mie_alu (
  mie_alu_if.alu u // operands in, result and carries out
);
  import mie_pkg::*;

  logic [8:0] diff;
  logic [4:0] diff_lo;
  logic [3:0] adj_lo;
  logic [3:0] adj_hi;
  logic fix_lo;
  logic fix_hi;

  // operation select
  always_comb begin
    diff = {1'b0, u.b} - {1'b0, u.a} - {8'h00, u.cin};
    diff_lo = {1'b0, u.b[3:0]} - {1'b0, u.a[3:0]} - {4'h0, u.cin};
    fix_lo = (u.a[3:0] > `MIE_NIBBLE_MAX) || u.dcin;
    fix_hi = (u.a[7:4] > `MIE_NIBBLE_MAX) || u.cin;
    adj_lo = fix_lo ? u.a[3:0] + `MIE_NIBBLE_ADJ : u.a[3:0];
    adj_hi = fix_hi ? u.a[7:4] + `MIE_NIBBLE_ADJ : u.a[7:4];
    u.res = u.b;
    u.cout = u.cin;
    u.dcout = u.dcin;
    case (u.op)
      MIE_ALU_INC: u.res = u.b + 8'h01;
      MIE_ALU_DEC: u.res = u.b - 8'h01;
      MIE_ALU_OR: u.res = u.a | u.b;
      MIE_ALU_ROL: begin
        u.res = {u.b[6:0], u.cin};
        u.cout = u.b[7];
      end
      MIE_ALU_ROR: begin
        u.res = {u.cin, u.b[7:1]};
        u.cout = u.b[0];
      end
      MIE_ALU_SBC: begin
        u.res = diff[7:0];
        u.cout = ~diff[8]; // set when no borrow
        u.dcout = ~diff_lo[4];
      end
      MIE_ALU_DAA: begin
        u.res = {adj_hi, adj_lo};
        u.cout = fix_hi;
      end
      default: u.res = u.b;
    endcase
  end
endmodule
`default_nettype wire

/* File: verilog/mie_exec.sv */
/*
  Execute stage for a subset of an 8-bit controller instruction set. Holds the
  working register, carry, half carry, zero, interrupt enable and the sleep
  status bits; drives register, port control, special function, stack and
  program counter strobes. Assumes the fetch stage hands over each word with
  the addressed register's content in the same cycle, and that pc_plus1_i is
  the address of the word after the one executing.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mie_cfg.svh"
module mie_exec #(
  parameter int SFR_COUNT = 16 // special function registers present
) (
  input wire logic sys_clk_i, // core instruction clock
  input wire logic srst_i, // synchronous reset, high
  input wire logic [13:0] instr_i, // instruction word
  input wire logic instr_valid_i, // word present this cycle
  input wire logic [7:0] reg_rdata_i, // content of register instr_i[6:0]
  input wire logic [10:0] pc_plus1_i, // address of next word
  input wire logic [10:0] tos_i, // top of stack
  input wire logic status_page_i, // status register bit 5
  input wire logic [7:0] table_high_pointer_i, // table_high_pointer
  input wire logic [7:0] port_ctrl_rdata_i, // selected port control reg
  input wire logic [7:0] sfr_rdata_i, // selected special function reg
  input wire logic wake_i, // wake-up event, same clock
  output logic [7:0] acc_o, // working_register
  output logic carry_o, // carry flag
  output logic half_carry_o, // half_carry flag
  output logic zero_o, // zero flag
  output logic gie_o, // global interrupt enable
  output logic reg_we_o, // register write strobe
  output logic [6:0] reg_waddr_o, // register write address
  output logic [7:0] wr_data_o, // data for every write strobe
  output logic port_ctrl_we_o, // port control write strobe
  output logic [3:0] sel_o, // port control / special function index
  output logic sfr_we_o, // special function write strobe
  output logic pc_load_o, // load pc with pc_target_o
  output logic [10:0] pc_target_o, // new program counter
  output logic push_o, // push push_data_o
  output logic [10:0] push_data_o, // return address
  output logic pop_o, // pop top of stack
  output logic discard_o, // discard the fetched word
  output logic busy_o, // no word taken this cycle
  output logic wdt_clr_o, // clear watchdog and prescaler
  output logic timeout_flag_o, // timeout_flag
  output logic power_down_flag_o, // power_down_flag
  output logic sleep_o // core halted in sleep
);
  import mie_pkg::*;

  // refuse index ranges that the four-bit selector cannot serve
  if (SFR_COUNT < 1 || SFR_COUNT > 16) begin : g_sfr_count_bad
    $error("SFR_COUNT must lie in 1..16");
  end

  mie_alu_if aif ();
  mie_alu u_alu (.u(aif.alu));

  mie_state_t state, next_state;
  logic [1:0] hold, next_hold;
  logic [7:0] acc, next_acc;
  logic carry, next_carry;
  logic hcarry, next_hcarry;
  logic zero, next_zero;
  logic gie, next_gie;
  logic to_flag, next_to_flag;
  logic pd_flag, next_pd_flag;
  logic reg_we, next_reg_we;
  logic [6:0] reg_waddr, next_reg_waddr;
  logic [7:0] wr_data, next_wr_data;
  logic port_we, next_port_we;
  logic [3:0] sel, next_sel;
  logic sfr_we, next_sfr_we;
  logic pc_load, next_pc_load;
  logic [10:0] pc_target, next_pc_target;
  logic push, next_push;
  logic [10:0] push_data, next_push_data;
  logic pop, next_pop;
  logic discard, next_discard;
  logic wdt_clr, next_wdt_clr;
  logic busy, next_busy;
  logic sleep, next_sleep;

  logic [5:0] op6;
  logic dest;
  logic take;
  logic [7:0] result;

  // decode fields and drive the arithmetic unit
  always_comb begin
    op6 = instr_i[13:8];
    dest = instr_i[`MIE_DEST_BIT];
    take = (state == MIE_ST_EXEC) && instr_valid_i;
    aif.a = acc;
    aif.b = reg_rdata_i;
    aif.cin = carry;
    aif.dcin = hcarry;
    aif.op = MIE_ALU_PASS;
    case (op6)
      `MIE_OP_PLUS_ONE, `MIE_OP_PLUS_ONE_SZ: aif.op = MIE_ALU_INC;
      `MIE_OP_MINUS_ONE, `MIE_OP_MINUS_ONE_SZ: aif.op = MIE_ALU_DEC;
      `MIE_OP_OR_REG: aif.op = MIE_ALU_OR;
      `MIE_OP_OR_LIT: begin
        aif.op = MIE_ALU_OR;
        aif.b = instr_i[7:0];
      end
      `MIE_OP_ROT_LEFT: aif.op = MIE_ALU_ROL;
      `MIE_OP_ROT_RIGHT: aif.op = MIE_ALU_ROR;
      `MIE_OP_SUB_REG: aif.op = MIE_ALU_SBC;
      `MIE_OP_SUB_LIT: begin
        aif.op = MIE_ALU_SBC;
        aif.b = instr_i[7:0];
      end
      `MIE_OP_MISC: aif.op = MIE_ALU_DAA;
      default: aif.op = MIE_ALU_PASS;
    endcase
    result = aif.res;
  end

  // next state of the sequencer, the held registers and the strobes
  always_comb begin
    next_state = state;
    next_hold = hold;
    next_acc = acc;
    next_carry = carry;
    next_hcarry = hcarry;
    next_zero = zero;
    next_gie = gie;
    next_to_flag = to_flag;
    next_pd_flag = pd_flag;
    next_reg_we = 1'b0;
    next_reg_waddr = instr_i[6:0];
    next_wr_data = wr_data;
    next_port_we = 1'b0;
    next_sel = sel;
    next_sfr_we = 1'b0;
    next_pc_load = 1'b0;
    next_pc_target = pc_target;
    next_push = 1'b0;
    next_push_data = push_data;
    next_pop = 1'b0;
    next_discard = 1'b0;
    next_wdt_clr = 1'b0;
    case (state)
      MIE_ST_EXEC: begin
        if (take) begin
          case (op6)
            `MIE_OP_PLUS_ONE, `MIE_OP_MINUS_ONE, `MIE_OP_OR_REG, `MIE_OP_COPY_REG: begin
              next_zero = (result == 8'h00);
              if (dest) begin
                next_reg_we = 1'b1;
                next_wr_data = result;
              end else begin
                next_acc = result;
              end
            end
            `MIE_OP_PLUS_ONE_SZ, `MIE_OP_MINUS_ONE_SZ: begin
              if (dest) begin
                next_reg_we = 1'b1;
                next_wr_data = result;
              end else begin
                next_acc = result;
              end
              if (result == 8'h00) begin
                next_discard = 1'b1;
                next_hold = `MIE_HOLD_BRANCH;
                next_state = MIE_ST_HOLD;
              end
            end
            `MIE_OP_ROT_LEFT, `MIE_OP_ROT_RIGHT: begin
              next_carry = aif.cout;
              if (dest) begin
                next_reg_we = 1'b1;
                next_wr_data = result;
              end else begin
                next_acc = result;
              end
            end
            `MIE_OP_SUB_REG: begin
              next_carry = aif.cout;
              next_hcarry = aif.dcout;
              next_zero = (result == 8'h00);
              if (dest) begin
                next_reg_we = 1'b1;
                next_wr_data = result;
              end else begin
                next_acc = result;
              end
            end
            `MIE_OP_SUB_LIT: begin
              next_carry = aif.cout;
              next_hcarry = aif.dcout;
              next_zero = (result == 8'h00);
              next_acc = result;
            end
            `MIE_OP_OR_LIT: begin
              next_zero = (result == 8'h00);
              next_acc = result;
            end
            `MIE_OP_LOAD_LIT: next_acc = instr_i[7:0];
            `MIE_OP_EXIT_LIT: begin
              next_acc = instr_i[7:0];
              next_pop = 1'b1;
              next_pc_load = 1'b1;
              next_pc_target = tos_i;
              next_discard = 1'b1;
              next_hold = `MIE_HOLD_BRANCH;
              next_state = MIE_ST_HOLD;
            end
            default: begin
            end
          endcase
          // store_working_to_reg: misc group with bit 7 set
          if (op6 == `MIE_OP_MISC && instr_i[7]) begin
            next_reg_we = 1'b1;
            next_wr_data = acc;
          end
          // single-word misc codes and selector forms
          if (op6 == `MIE_OP_MISC && !instr_i[7]) begin
            case (instr_i[7:4])
              `MIE_SEL_PORT_WR: begin
                if (instr_i[3:0] >= `MIE_PORT_SEL_MIN) begin
                  next_port_we = 1'b1;
                  next_sel = instr_i[3:0];
                  next_wr_data = acc;
                end
              end
              `MIE_SEL_PORT_RD: begin
                if (instr_i[3:0] >= `MIE_PORT_SEL_MIN) begin
                  next_acc = port_ctrl_rdata_i;
                  next_sel = instr_i[3:0];
                end
              end
              `MIE_SEL_SFR_WR: begin
                if ({28'h0000000, instr_i[3:0]} < SFR_COUNT) begin
                  next_sfr_we = 1'b1;
                  next_sel = instr_i[3:0];
                  next_wr_data = acc;
                end
              end
              `MIE_SEL_SFR_RD: begin
                if ({28'h0000000, instr_i[3:0]} < SFR_COUNT) begin
                  next_acc = sfr_rdata_i;
                  next_sel = instr_i[3:0];
                end
              end
              default: begin
                case (instr_i[7:0])
                  `MIE_MISC_DEC_ADJ: begin
                    next_acc = result;
                    next_carry = aif.cout;
                  end
                  `MIE_MISC_IRQ_OFF: next_gie = 1'b0;
                  `MIE_MISC_IRQ_ON: next_gie = 1'b1;
                  `MIE_MISC_SUB_EXIT, `MIE_MISC_IRQ_EXIT: begin
                    next_pop = 1'b1;
                    next_pc_load = 1'b1;
                    next_pc_target = tos_i;
                    next_discard = 1'b1;
                    next_hold = `MIE_HOLD_BRANCH;
                    next_state = MIE_ST_HOLD;
                    if (instr_i[7:0] == `MIE_MISC_IRQ_EXIT) begin
                      next_gie = 1'b1;
                    end
                  end
                  `MIE_MISC_TRAP: begin
                    next_push = 1'b1;
                    next_push_data = pc_plus1_i;
                    next_pc_load = 1'b1;
                    next_pc_target = `MIE_TRAP_VECTOR;
                    next_discard = 1'b1;
                    next_hold = `MIE_HOLD_TRAP;
                    next_state = MIE_ST_HOLD;
                  end
                  `MIE_MISC_SLEEP: begin
                    next_wdt_clr = 1'b1;
                    next_to_flag = 1'b1;
                    next_pd_flag = 1'b0;
                    next_state = MIE_ST_SLEEP;
                  end
                  default: begin
                  end
                endcase
              end
            endcase
          end
          // computed jump is a whole-word code outside the misc major field
          if (instr_i == `MIE_OP_COMPUTED_JUMP) begin
            next_pc_load = 1'b1;
            next_pc_target = {pc_plus1_i[10], table_high_pointer_i[1:0], acc};
            next_discard = 1'b1;
            next_hold = `MIE_HOLD_BRANCH;
            next_state = MIE_ST_HOLD;
          end
          // paged and long branches decoded on shorter fields
          if (instr_i[13:9] == `MIE_OP_SHORT_JUMP) begin
            next_pc_load = 1'b1;
            next_pc_target = {pc_plus1_i[10], status_page_i, instr_i[8:0]};
            next_discard = 1'b1;
            next_hold = `MIE_HOLD_BRANCH;
            next_state = MIE_ST_HOLD;
          end
          if (instr_i[13:11] == `MIE_OP_LONG_CALL || instr_i[13:11] == `MIE_OP_LONG_JUMP) begin
            next_pc_load = 1'b1;
            next_pc_target = instr_i[10:0];
            next_push = (instr_i[13:11] == `MIE_OP_LONG_CALL);
            next_push_data = pc_plus1_i;
            next_discard = 1'b1;
            next_hold = `MIE_HOLD_BRANCH;
            next_state = MIE_ST_HOLD;
          end
        end
      end
      MIE_ST_HOLD: begin
        next_hold = hold - 2'h1; // fetched word dropped, nop cycle
        if (hold == 2'h1) begin
          next_state = MIE_ST_EXEC;
        end
      end
      MIE_ST_SLEEP: begin
        if (wake_i) begin
          next_state = MIE_ST_EXEC;
        end
      end
      default: next_state = MIE_ST_EXEC;
    endcase
    // status levels registered so the ports come from flops
    next_busy = (next_state != MIE_ST_EXEC);
    next_sleep = (next_state == MIE_ST_SLEEP);
  end

  // register the sequencer, held state and strobes
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state <= MIE_ST_EXEC;
      hold <= 2'h0;
      acc <= `MIE_RST_ACC;
      carry <= 1'b0;
      hcarry <= 1'b0;
      zero <= 1'b0;
      gie <= `MIE_RST_GIE;
      to_flag <= `MIE_RST_TIMEOUT;
      pd_flag <= `MIE_RST_POWER_DOWN;
      reg_we <= 1'b0;
      reg_waddr <= 7'h00;
      wr_data <= 8'h00;
      port_we <= 1'b0;
      sel <= 4'h0;
      sfr_we <= 1'b0;
      pc_load <= 1'b0;
      pc_target <= 11'h000;
      push <= 1'b0;
      push_data <= 11'h000;
      pop <= 1'b0;
      discard <= 1'b0;
      wdt_clr <= 1'b0;
      busy <= 1'b0;
      sleep <= 1'b0;
    end else begin
      state <= next_state;
      hold <= next_hold;
      acc <= next_acc;
      carry <= next_carry;
      hcarry <= next_hcarry;
      zero <= next_zero;
      gie <= next_gie;
      to_flag <= next_to_flag;
      pd_flag <= next_pd_flag;
      reg_we <= next_reg_we;
      reg_waddr <= next_reg_waddr;
      wr_data <= next_wr_data;
      port_we <= next_port_we;
      sel <= next_sel;
      sfr_we <= next_sfr_we;
      pc_load <= next_pc_load;
      pc_target <= next_pc_target;
      push <= next_push;
      push_data <= next_push_data;
      pop <= next_pop;
      discard <= next_discard;
      wdt_clr <= next_wdt_clr;
      busy <= next_busy;
      sleep <= next_sleep;
    end
  end

  // outputs straight from flops
  assign acc_o = acc;
  assign carry_o = carry;
  assign half_carry_o = hcarry;
  assign zero_o = zero;
  assign gie_o = gie;
  assign reg_we_o = reg_we;
  assign reg_waddr_o = reg_waddr;
  assign wr_data_o = wr_data;
  assign port_ctrl_we_o = port_we;
  assign sel_o = sel;
  assign sfr_we_o = sfr_we;
  assign pc_load_o = pc_load;
  assign pc_target_o = pc_target;
  assign push_o = push;
  assign push_data_o = push_data;
  assign pop_o = pop;
  assign discard_o = discard;
  assign busy_o = busy;
  assign wdt_clr_o = wdt_clr;
  assign timeout_flag_o = to_flag;
  assign power_down_flag_o = pd_flag;
  assign sleep_o = sleep;
endmodule
`default_nettype wire

/* File: verification/mie_exec_sva.sv */
/* checker of the execute block, watching its top ports only
   assumes one clock and a synchronous reset */
`timescale 1ns/1ps
`default_nettype none
module mie_exec_sva (
  input wire logic sys_clk_i, srst_i, instr_valid_i, status_page_i, busy_o, carry_o, zero_o, gie_o,
  input wire logic pc_load_o, push_o, pop_o, wdt_clr_o, timeout_flag_o, power_down_flag_o, sleep_o,
  input wire logic [13:0] instr_i,
  input wire logic [10:0] pc_plus1_i, tos_i, pc_target_o, push_data_o,
  input wire logic [7:0] acc_o
);
  wire logic tk;
  // a word is taken at this edge
  assign tk = instr_valid_i & ~busy_o;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  dec_adj_a: assert property (tk && instr_i == 14'h0006 |=> carry_o == ($past(acc_o[7:4]) > 4'h9 || $past(carry_o)))
    else $error("adjust carry wrong");
  skip_keep_a: assert property (tk && instr_i[13:9] == 5'h07 |=> $stable(zero_o) && $stable(carry_o))
    else $error("skip form changed flags");
  irq_on_a: assert property (tk && instr_i == 14'h0002 |=> gie_o)
    else $error("enable not set");
  short_jump_a: assert property (tk && instr_i[13:9] == 5'h0D |=> pc_load_o && pc_target_o[9:0] == {$past(status_page_i), $past(instr_i[8:0])})
    else $error("short jump target wrong");
  trap_call_a: assert property (tk && instr_i == 14'h0007 |=> push_o && pc_load_o && pc_target_o == 11'h001 ##1 busy_o ##1 !busy_o)
    else $error("trap call wrong");
  long_call_a: assert property (tk && instr_i[13:11] == 3'h6 |=> push_o && push_data_o == $past(pc_plus1_i) && pc_target_o == $past(instr_i[10:0]) ##1 !busy_o)
    else $error("long call wrong");
  sub_exit_a: assert property (tk && instr_i == 14'h0004 |=> pop_o && pc_target_o == $past(tos_i) && $stable(gie_o))
    else $error("return wrong");
  sleep_entry_a: assert property (tk && instr_i == 14'h0001 |=> wdt_clr_o && timeout_flag_o && !power_down_flag_o && sleep_o)
    else $error("sleep entry wrong");
endmodule
bind mie_exec mie_exec_sva i_sva (.*);
`default_nettype wire

/* File: verification/tb_mie_exec.sv */
/* self-checking bench of the execute block
   assumes the checker is bound in from its own file */
`timescale 1ns/1ps
`default_nettype none
module tb_mie_exec;
  logic sys_clk_i = 1'b0, srst_i = 1'b1, instr_valid_i = 1'b0, status_page_i = 1'b1, wake_i = 1'b0;
  logic [13:0] instr_i = 14'h0000;
  logic [10:0] pc_plus1_i = 11'h400, tos_i = 11'h2AB, pc_target_o, push_data_o;
  logic [7:0] reg_rdata_i = 8'h00, table_high_pointer_i = 8'h02, port_ctrl_rdata_i = 8'h3C, sfr_rdata_i = 8'hC3, acc_o, wr_data_o;
  logic [6:0] reg_waddr_o;
  logic [3:0] sel_o;
  logic carry_o, half_carry_o, zero_o, gie_o, reg_we_o, port_ctrl_we_o, sfr_we_o, pc_load_o, push_o, pop_o;
  logic discard_o, busy_o, wdt_clr_o, timeout_flag_o, power_down_flag_o, sleep_o;
  int err_count = 0, samples_checked = 0, cyc = 0;
  mie_exec i_dut (.*);
  // clock and hang guard
  always #10 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 1000) begin
      err_count++;
      print_verdict();
    end
  end
  task c(input string n, input logic [10:0] g, input logic [10:0] e);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  // one word, results settle just after the taking edge
  task x(input logic [13:0] w, input logic [7:0] r);
    @(posedge sys_clk_i);
    #1;
    while (busy_o !== 1'b0) begin
      @(posedge sys_clk_i);
      #1;
    end
    instr_i = w;
    reg_rdata_i = r;
    instr_valid_i = 1'b1;
    @(posedge sys_clk_i);
    #1 instr_valid_i = 1'b0;
  endtask
  task print_verdict;
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // instruction sequence with expected results
  initial begin
    repeat (4) @(posedge sys_clk_i);
    #1 srst_i = 1'b0;
    c("rst", {acc_o, gie_o, timeout_flag_o, power_down_flag_o}, 11'h003);
    x(14'h1138, 8'h00); x(14'h1301, 8'h00); c("or", {acc_o, zero_o}, 11'h072);
    x(14'h0C00, 8'h80); c("rol", {acc_o, carry_o}, 11'h001);
    x(14'h119A, 8'h00); x(14'h0006, 8'h00); c("adj", {acc_o, carry_o}, 11'h1E1);
    x(14'h001F, 8'h00); c("pwr", {port_ctrl_we_o, sel_o}, 11'h01F); c("wd", wr_data_o, 11'h0F0);
    x(14'h0012, 8'h00); c("pbad", {port_ctrl_we_o, sel_o}, 11'h00F);
    x(14'h00FF, 8'h00); c("st", {reg_we_o, reg_waddr_o}, 11'h0FF);
    x(14'h0030, 8'h00); c("sfw", {sfr_we_o, sel_o}, 11'h010);
    x(14'h0025, 8'h00); c("prd", acc_o, 11'h03C);
    x(14'h0040, 8'h00); c("srd", acc_o, 11'h0C3);
    x(14'h0B82, 8'h02); c("ror", {wr_data_o, carry_o}, 11'h102);
    x(14'h1101, 8'h00); x(14'h1801, 8'h00); c("sbl", {acc_o, carry_o, half_carry_o, zero_o}, 11'h007);
    x(14'h1D00, 8'h00); c("sbr", {acc_o, carry_o, half_carry_o, zero_o}, 11'h7F8);
    x(14'h0E80, 8'hFF); c("skp", {wr_data_o, discard_o, busy_o, zero_o}, 11'h006);
    c("skw", reg_we_o, 11'h001);
    x(14'h0500, 8'hFF); c("inc", {acc_o, zero_o}, 11'h001);
    x(14'h0680, 8'h01); c("dec", {reg_we_o, wr_data_o, zero_o}, 11'h201);
    x(14'h0100, 8'h55); c("mov", {acc_o, zero_o}, 11'h0AA);
    x(14'h0002, 8'h00); c("on", gie_o, 11'h001);
    x(14'h0003, 8'h00); c("off", gie_o, 11'h000);
    x(14'h0005, 8'h00); c("rti", {gie_o, pop_o}, 11'h003); c("rtt", pc_target_o, 11'h2AB);
    x(14'h1B55, 8'h00); c("sj", pc_target_o, 11'h755);
    x(14'h0213, 8'h00); c("cj", pc_target_o, 11'h655);
    x(14'h3FFF, 8'h00); c("lj", pc_target_o, 11'h7FF);
    c("ljs", push_o, 11'h000);
    x(14'h3123, 8'h00); c("lc", pc_target_o, 11'h123); c("lcp", push_data_o, 11'h400);
    x(14'h0007, 8'h00); c("trp", pc_target_o, 11'h001);
    c("trs", push_o, 11'h001);
    c("trd", push_data_o, 11'h400);
    @(posedge sys_clk_i);
    #1 c("trb", busy_o, 11'h001);
    x(14'h10A5, 8'h00); c("rtl", {acc_o, pop_o}, 11'h14B);
    x(14'h0004, 8'h00); c("ret", {pop_o, gie_o}, 11'h003);
    x(14'h0001, 8'h00); c("slp", {wdt_clr_o, timeout_flag_o, power_down_flag_o, sleep_o}, 11'h00D);
    @(posedge sys_clk_i);
    #1 c("slb", busy_o, 11'h001);
    wake_i = 1'b1;
    x(14'h1107, 8'h00); c("wk", acc_o, 11'h007);
    print_verdict();
  end
endmodule
`default_nettype wire
